// ==== design/rorel_top.sv ====
// relative reading unit: reference capture, difference, apb registers
// What this block does
// - an offset press latches the reading and later shows reading minus it.
// - the offset indicator is lit while a reference is applied.
// - the feature works in every measurement function.
// - the shown value always carries a sign while a reference applies; the code sets disp_signed only at the next reading.
// - a press while a reference applies cancels it and the indicator.
// - a capture in another function discards the old reference.
// - a press on an overrange or missing reading gives error 32, no store.
// - leaving the owning function suspends; returning reapplies.
// - overrange shows when the raw input or the difference overranges.
// - range choice comes from the raw input alone.
// - the display flashes above 1000V dc or 700V ac on the top range.
//
// The APB interface to the registers and the placing of the registers were decided locally.
module rorel_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic offset_press,
  input wire logic [rorel_pkg::FUNC_W-1:0] func,
  input wire logic [rorel_pkg::RANGE_W-1:0] range,
  input wire logic rd_valid,
  input wire logic [rorel_pkg::RD_W-1:0] rd_value,
  input wire logic rd_over,
  output logic [rorel_pkg::RD_W-1:0] disp_value,
  output logic disp_valid,
  output logic disp_over,
  output logic disp_signed,
  output logic disp_flash,
  output logic offset_ind,
  output logic [7:0] err_code,
  output logic err_pulse,
  output logic [rorel_pkg::RANGE_W-1:0] range_sel,
  output logic irq
);
  import rorel_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // reference state
  logic [23:0] ref_q, ref_d;
  logic [2:0] tag_q, tag_d;
  logic valid_q, valid_d;
  logic enable_q, enable_d;
  logic [7:0] err_q, err_d;
  logic err_p_q, err_p_d;
  logic capt_ev, err_ev;
  logic applied;
  logic ctrl_press;
  logic [23:0] raw_q, raw_d;
  logic raw_have_q, raw_have_d;
  logic raw_over_q, raw_over_d;
  logic raw_ok;

  // a reference applies only in its owning function
  assign applied = valid_q && enable_q && (tag_q == func);

  // last raw reading: the reading bus carries a value only in the
  // rd_valid cycle, so a later press must store this copy instead;
  // a press in the same cycle as a reading takes the previous one
  always_comb begin
    raw_d = raw_q;
    raw_have_d = raw_have_q;
    raw_over_d = raw_over_q;
    if (rd_valid) begin
      raw_d = rd_value;
      raw_have_d = 1'b1;
      raw_over_d = rd_over;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q <= REF_RST;
      raw_have_q <= 1'b0;
      raw_over_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
      raw_have_q <= raw_have_d;
      raw_over_q <= raw_over_d;
    end
  end

  // nothing since reset, or an overrange one, cannot be stored
  assign raw_ok = raw_have_q && !raw_over_q;

  always_comb begin
    ref_d = ref_q;
    tag_d = tag_q;
    valid_d = valid_q;
    enable_d = enable_q;
    err_d = err_q;
    err_p_d = 1'b0;
    capt_ev = 1'b0;
    err_ev = 1'b0;
    if (offset_press || ctrl_press) begin
      if (applied) begin
        // a press on an applied reference cancels, whatever the reading
        enable_d = 1'b0;
        valid_d = 1'b0;
      end else if (!raw_ok) begin
        err_d = ERR_NO_STORE;
        err_p_d = 1'b1;
        err_ev = 1'b1;
      end else begin
        // any function may own it; one slot replaces the old one
        ref_d = raw_q;
        tag_d = func;
        valid_d = 1'b1;
        enable_d = 1'b1;
        capt_ev = 1'b1;
      end
    end
  end

  // cleared at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= REF_RST;
      tag_q <= TAG_RST;
      valid_q <= 1'b0;
      enable_q <= 1'b0;
      err_q <= 8'h00;
      err_p_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      tag_q <= tag_d;
      valid_q <= valid_d;
      enable_q <= enable_d;
      err_q <= err_d;
      err_p_q <= err_p_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // datapath
  logic [23:0] diff;
  logic diff_over;
  logic flash;

  rorel_sub u_sub (
    .meas(rd_value),
    .ref_val(ref_q),
    .diff(diff),
    .diff_over(diff_over)
  );

  rorel_flash u_flash (
    .func(func),
    .range(range),
    .meas(rd_value),
    .flash(flash)
  );

  logic [23:0] dv_q, dv_d;
  logic dval_q, dval_d;
  logic dovr_q, dovr_d;
  logic dsgn_q, dsgn_d;
  logic dfl_q, dfl_d;
  logic ind_q, ind_d;

  // display registers update on each new reading; the indicator register follows applied every cycle
  always_comb begin
    dv_d = dv_q;
    dval_d = dval_q;
    dovr_d = dovr_q;
    dsgn_d = dsgn_q;
    dfl_d = dfl_q;
    ind_d = applied;
    if (rd_valid) begin
      dval_d = 1'b1;
      dfl_d = flash;
      dsgn_d = applied;
      if (applied) begin
        dv_d = diff;
        dovr_d = rd_over || diff_over;
      end else begin
        dv_d = rd_value;
        dovr_d = rd_over;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dv_q <= 24'h000000;
      dval_q <= 1'b0;
      dovr_q <= 1'b0;
      dsgn_q <= 1'b0;
      dfl_q <= 1'b0;
      ind_q <= 1'b0;
    end else begin
      dv_q <= dv_d;
      dval_q <= dval_d;
      dovr_q <= dovr_d;
      dsgn_q <= dsgn_d;
      dfl_q <= dfl_d;
      ind_q <= ind_d;
    end
  end

  assign disp_value = dv_q;
  assign disp_valid = dval_q;
  assign disp_over = dovr_q;
  assign disp_signed = dsgn_q;
  assign disp_flash = dfl_q;
  assign offset_ind = ind_q;
  assign err_code = err_q;
  assign err_pulse = err_p_q;
  // range passes straight on; the reference never steers it
  assign range_sel = range;

  ////////////////////////////////////////////////////////////////////
  // apb slave and interrupts
  logic [3:0] st_q;
  logic [3:0] mask_q, mask_d;
  logic [31:0] rd_q, rd_d;
  logic [3:0] ev;
  logic [3:0] seen;
  logic acc, wr, rd, setup_rd, st_rd;

  // access phase decode; pready is tied high so every access ends here
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  // read data is fetched in the setup cycle so that prdata leaves a flop
  assign setup_rd = psel && !penable && !pwrite;
  assign st_rd = rd && (paddr == ADDR_STATUS);
  assign ctrl_press = wr && (paddr == ADDR_CTRL) && pwdata[0];
  assign ev = {flash && rd_valid, dovr_d && rd_valid, err_ev, capt_ev};
  // clear only what the read returned: an event landing between the
  // fetch and the access edge stays pending for the next read
  assign seen = rd_q[ST_W-1:0];

  // one sticky bit per event; a new event wins over the read clear
  for (genvar i = 0; i < ST_W; i++) begin : g_st
    logic st_bit_d;

    always_comb begin
      st_bit_d = st_q[i];
      if (st_rd && seen[i]) begin
        st_bit_d = 1'b0;
      end
      if (ev[i]) begin
        st_bit_d = 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q[i] <= 1'b0;
      end else begin
        st_q[i] <= st_bit_d;
      end
    end
  end

  // mask writes and the read-data fetch
  always_comb begin
    mask_d = mask_q;
    rd_d = 32'h00000000;
    if (wr && paddr == ADDR_MASK) begin
      mask_d = pwdata[3:0];
    end
    if (setup_rd) begin
      unique case (paddr)
        ADDR_STATUS: rd_d = {28'h0, st_q};
        ADDR_MASK: rd_d = {28'h0, mask_q};
        ADDR_REF: rd_d = {8'h00, ref_q};
        ADDR_CTRL: rd_d = {27'h0, tag_q, valid_q, applied};
        ADDR_ERR: rd_d = {24'h0, err_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= MASK_RST;
      rd_q <= 32'h00000000;
    end else begin
      mask_q <= mask_d;
      rd_q <= rd_d;
    end
  end

  // the fetch register falls back to zero at the access edge, so
  // prdata stands for the access phase and reads zero otherwise
  assign prdata = rd_q;
  // zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = acc && !(paddr == ADDR_STATUS || paddr == ADDR_MASK ||
    paddr == ADDR_REF || paddr == ADDR_CTRL || paddr == ADDR_ERR);
  // level interrupt while any unmasked sticky bit is set
  assign irq = |(st_q & mask_q);
endmodule : rorel_top

// ==== design/rorel_pkg.sv ====
// package of constants and types for the relative reading unit
package rorel_pkg;
  // reading format: signed counts, displayable magnitude limit
  localparam int RD_W = 24;
  localparam logic [23:0] DISP_MAX = 24'h030d3f; // 199999 counts
  // function codes
  localparam int FUNC_W = 3;
  localparam logic [2:0] FN_VDC = 3'h1;
  localparam logic [2:0] FN_VAC = 3'h2;
  // range code of the highest voltage range
  localparam int RANGE_W = 3;
  localparam logic [2:0] RNG_TOP = 3'h5;
  // flash thresholds in counts of the top range
  localparam logic [23:0] DC_FLASH_LIM = 24'h0186a0; // 1000V as 100000
  localparam logic [23:0] AC_FLASH_LIM = 24'h011170; // 700V as 70000
  // error code on refused capture
  localparam logic [7:0] ERR_NO_STORE = 8'h20; // 32
  // apb register map
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_REF = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_ERR = 8'h10;
  // status bits
  localparam int ST_CAPT = 0;
  localparam int ST_ERR = 1;
  localparam int ST_OVR = 2;
  localparam int ST_FLASH = 3;
  localparam int ST_W = 4;
  // reset values
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [23:0] REF_RST = 24'h000000;
  localparam logic [2:0] TAG_RST = 3'h0;
endpackage : rorel_pkg

// ==== design/rorel_sub.sv ====
// signed subtractor with displayable-range check
module rorel_sub (
  input wire logic [23:0] meas,
  input wire logic [23:0] ref_val,
  output logic [23:0] diff,
  output logic diff_over
);
  import rorel_pkg::*;
  logic [24:0] wide;
  logic [24:0] mag;
  // widen by one bit so the difference cannot wrap
  always_comb begin
    wide = {meas[23], meas} - {ref_val[23], ref_val};
    mag = wide[24] ? (25'h0 - wide) : wide;
    diff = wide[23:0];
    diff_over = (mag > {1'b0, DISP_MAX});
  end
endmodule : rorel_sub

// ==== design/rorel_flash.sv ====
// flash detect for the top voltage ranges
module rorel_flash (
  input wire logic [2:0] func,
  input wire logic [2:0] range,
  input wire logic [23:0] meas,
  output logic flash
);
  import rorel_pkg::*;
  logic [23:0] mag;
  // independent of the reference; looks at raw input only
  always_comb begin
    mag = meas[23] ? (24'h0 - meas) : meas;
    flash = 1'b0;
    if (range == RNG_TOP && func == FN_VDC && mag > DC_FLASH_LIM) begin
      flash = 1'b1;
    end
    if (range == RNG_TOP && func == FN_VAC && mag > AC_FLASH_LIM) begin
      flash = 1'b1;
    end
  end
endmodule : rorel_flash

// ==== bench/rorel_chk.sv ====
// concurrent checks on the relative reading unit ports
module rorel_chk
  import rorel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic offset_press,
  input wire logic [2:0] func,
  input wire logic [2:0] range,
  input wire logic rd_valid,
  input wire logic rd_over,
  input wire logic disp_valid,
  input wire logic disp_over,
  input wire logic disp_signed,
  input wire logic disp_flash,
  input wire logic offset_ind,
  input wire logic [7:0] err_code,
  input wire logic err_pulse,
  input wire logic [2:0] range_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_err_code: assert property (
    err_pulse |-> err_code == ERR_NO_STORE) else $error("bad error code");
  a_no_reading: assert property (
    offset_press && !disp_valid |=> err_pulse) else $error("no refusal");
  a_range_raw: assert property (
    range_sel == range) else $error("range not from input");
  a_ind_leave: assert property (
    $changed(func) && offset_ind |=> !offset_ind) else $error("ind kept");
  a_press_cancel: assert property (
    offset_press && offset_ind && $stable(func) |=> ##1 !offset_ind)
    else $error("no cancel");
  a_press_capture: assert property (
    offset_press && !offset_ind && disp_valid && !disp_over && $stable(func)
    |=> ##1 offset_ind) else $error("no capture");
  a_sign_forced: assert property (
    rd_valid && offset_ind && $past(offset_ind) && !$past(offset_press)
    && $stable(func) |=> disp_signed) else $error("sign not forced");
  a_raw_over: assert property (
    rd_valid && rd_over |=> disp_over) else $error("over not shown");
  a_flash_off: assert property (
    rd_valid && range != RNG_TOP |=> !disp_flash) else $error("bad flash");
endmodule : rorel_chk
////////////////////////////////////////////////////////////////////////////
bind rorel_top rorel_chk i_chk (.*);

// ==== bench/rorel_model.sv ====
// measurement engine model feeding readings
module rorel_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [23:0] val,
  input wire logic ovr,
  output logic rd_valid = 1'b0,
  output logic [23:0] rd_value = 24'h5a5a5a,
  output logic rd_over = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one pulse per reading; the bus toggles between readings, never holds
  always_ff @(posedge pclk) begin
    rd_valid <= go;
    rd_value <= go ? val : ~rd_value;
    rd_over <= go ? ovr : ~rd_over;
  end
endmodule : rorel_model

// ==== bench/rorel_top_tb.sv ====
// testbench for the relative reading unit
module rorel_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rorel_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, m_go, m_ovr;
  logic offset_press, rd_valid, rd_over, disp_valid, disp_over, disp_signed;
  logic disp_flash, offset_ind, err_pulse, irq;
  logic [7:0] paddr, err_code;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] func, range, range_sel;
  logic [23:0] rd_value, disp_value, m_val;
  int failures, checked;
  logic slv_err;
  rorel_top i_dut (.*);
  rorel_model i_mdl (.pclk, .go(m_go), .val(m_val), .ovr(m_ovr), .rd_valid,
    .rd_value, .rd_over);
  ////////////////////////////////////////////////////////////////////////
  // clock at 40 ns period
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // one apb transfer; waits on pready, only the watchdog ends a hang
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv_err = pslverr;
    {psel, penable} <= 2'b00;
    // idle cycle so a following call never rewrites psel at once
    @(posedge pclk);
  endtask : apb
  task automatic meas(logic [23:0] v, logic o);
    {m_go, m_val, m_ovr} <= {1'b1, v, o};
    @(posedge pclk) m_go <= 0;
    repeat (3) @(posedge pclk);
  endtask : meas
  task automatic press();
    offset_press <= 1;
    @(posedge pclk) offset_press <= 0;
    repeat (3) @(posedge pclk);
  endtask : press
  task automatic to_func(logic [2:0] f);
    func <= f;
    repeat (3) @(posedge pclk);
  endtask : to_func
  task automatic complete_run();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {offset_press, m_go, m_val, m_ovr, func, range} = {27'h0, FN_VDC, 3'h3};
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ADDR_REF, 0);
    chk("ref", rd, 0);
    chk("okay", slv_err, 0);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl", rd, 0);
    apb(1, ADDR_MASK, 32'hf);
    press();
    chk("err", err_code, 8'h20);
    chk("irq", irq, 1);
    apb(0, ADDR_STATUS, 0);
    chk("st", rd[ST_ERR], 1);
    chk("irqclr", irq, 0);
    meas(24'h000064, 0);
    press();
    chk("ind", offset_ind, 1);
    apb(0, ADDR_REF, 0);
    chk("ref", rd, 32'h64);
    chk("dval", disp_valid, 1);
    meas(24'h0000c8, 0);
    chk("diff", disp_value, 24'h000064);
    chk("sign", disp_signed, 1);
    meas(24'h000032, 0);
    chk("neg", disp_value, 24'hffffce);
    meas(24'hfcf2f2, 0);
    chk("dover", disp_over, 1);
    meas(24'h000010, 1);
    chk("rover", disp_over, 1);
    to_func(FN_VAC);
    chk("ind", offset_ind, 0);
    to_func(FN_VDC);
    chk("ind", offset_ind, 1);
    to_func(FN_VAC);
    range <= RNG_TOP;
    meas(24'h011171, 0);
    chk("flash", disp_flash, 1);
    chk("rsel", range_sel, RNG_TOP);
    press();
    apb(0, ADDR_REF, 0);
    chk("ref", rd, 32'h11171);
    to_func(FN_VDC);
    chk("ind", offset_ind, 0);
    // the old dc reference of 0x64 is gone: the raw value shows
    meas(24'h000064, 0);
    chk("raw", disp_value, 24'h000064);
    chk("unsg", disp_signed, 0);
    to_func(FN_VAC);
    press();
    chk("ind", offset_ind, 0);
    // a function other than dc or ac voltage works the same way
    to_func(3'h3);
    meas(24'h001000, 0);
    press();
    meas(24'h001800, 0);
    chk("ohm", disp_value, 24'h000800);
    chk("osgn", disp_signed, 1);
    apb(0, 8'h20, 0);
    chk("unmap", rd, 0);
    chk("slverr", slv_err, 1);
    // second reset in mid-run: the stored reference must be gone
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl", rd, 0);
    apb(0, ADDR_REF, 0);
    chk("ref", rd, 0);
    complete_run();
  end
endmodule : rorel_top_tb
